// ---- include/dpw_pkg.sv ----
// Shared constants and state types for the wiper control link
package dpw_pkg;
    // Clock and serial timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SCL_PERIOD_NS = 10000;
    localparam int unsigned SCL_QUARTER_CYC =
        SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // Target address: six fixed upper bits, strap supplies the lowest
    localparam logic [5:0] ADDR_FIXED = 6'h16;
    // Wiper codes
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    localparam logic [7:0] WIPER_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    // Instruction byte fields
    localparam int unsigned INSTR_MID_RST_POS = 6;
    localparam int unsigned INSTR_SHDN_POS = 5;
    // Bits in one byte, and slot of the acknowledge
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Controller register offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_INSTR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    // Control register fields
    localparam int unsigned CTRL_GO_POS = 0;
    localparam int unsigned CTRL_READ_POS = 1;
    localparam int unsigned CTRL_ASEL_POS = 2;
    // Status register fields
    localparam int unsigned STAT_BUSY_POS = 0;
    localparam int unsigned STAT_NACK_POS = 1;
    localparam int unsigned STAT_DONE_POS = 2;
    // Target receiver states
    typedef enum logic [3:0] {
        DPW_T_IDLE,
        DPW_T_ADDR,
        DPW_T_ACK_ADDR,
        DPW_T_INSTR,
        DPW_T_ACK_INSTR,
        DPW_T_DATA,
        DPW_T_ACK_DATA,
        DPW_T_READ,
        DPW_T_READ_ACK
    } dpw_tgt_state_t;
    // Controller sequencer states
    typedef enum logic [1:0] {
        DPW_C_IDLE,
        DPW_C_START,
        DPW_C_BITS,
        DPW_C_STOP
    } dpw_ctl_state_t;
endpackage

// ---- include/dpw_bus_if.sv ----
// Two-wire open-drain bus joining controller and target
`timescale 1ns/1ns
interface dpw_bus_if;
    logic scl_o;
    logic scl_oe_n;
    logic ctl_sda_o;
    logic ctl_sda_oe_n;
    logic tgt_sda_o;
    logic tgt_sda_oe_n;
    logic scl;
    logic sda;

    // Wired-AND with pull-up: a line is low when any driver pulls it low
    assign scl = scl_oe_n | scl_o;
    assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);

    modport ctl (
        output scl_o,
        output scl_oe_n,
        output ctl_sda_o,
        output ctl_sda_oe_n,
        input scl,
        input sda
    );
    modport tgt (
        output tgt_sda_o,
        output tgt_sda_oe_n,
        input scl,
        input sda
    );
endinterface

// ---- logic/dpw_target.sv ----
// Serial target that sets, resets and shuts down the wiper
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module dpw_target
    import dpw_pkg::*;
#(
    parameter int unsigned WIPER_W = 8
) (
    input wire logic mclk,
    input wire logic srst,
    dpw_bus_if.tgt bus,
    input wire logic addr_select_pin,
    output logic [WIPER_W-1:0] wiper_register,
    output logic [WIPER_W-1:0] tap_code,
    output logic top_open
);
    localparam int unsigned NSYNC = 3;

    logic [NSYNC-1:0] pin_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;
    logic [NSYNC-1:0] prev_q;
    logic scl_f;
    logic sda_f;
    logic asel_f;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    dpw_tgt_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rx_byte;
    logic [WIPER_W-1:0] wiper_q;
    logic shutdown_q;
    logic sda_oe_n_q;
    logic sda_o_q;
    logic [WIPER_W-1:0] tap_q;
    logic top_open_q;
    logic master_ack_q;

    assign pin_in = {addr_select_pin, bus.sda, bus.scl};

    // Three-stage synchronisers; a level counts once stages two and three agree
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (srst) begin
                s1_q[i] <= 1'b1;
                s2_q[i] <= 1'b1;
                s3_q[i] <= 1'b1;
                filt_q[i] <= 1'b1;
                prev_q[i] <= 1'b1;
            end else begin
                s1_q[i] <= pin_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    filt_q[i] <= s3_q[i];
                end
                prev_q[i] <= filt_q[i];
            end
        end
    end

    assign scl_f = filt_q[0];
    assign sda_f = filt_q[1];
    assign asel_f = filt_q[2];
    assign scl_rise = scl_f & ~prev_q[0];
    assign scl_fall = ~scl_f & prev_q[0];
    // Bus conditions: SDA edge while SCL stays high
    assign start_det = scl_f & prev_q[0] & prev_q[1] & ~sda_f;
    assign stop_det = scl_f & prev_q[0] & ~prev_q[1] & sda_f;
    assign rx_byte = shift_q;

    // Protocol sequencer with bit counter and shift register
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= DPW_T_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            sda_oe_n_q <= 1'b1;
            master_ack_q <= 1'b1;
        end else if (start_det) begin
            state_q <= DPW_T_ADDR;
            cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
        end else if (stop_det) begin
            state_q <= DPW_T_IDLE;
            sda_oe_n_q <= 1'b1;
        end else begin
            unique case (state_q)
                DPW_T_IDLE: begin
                    sda_oe_n_q <= 1'b1;
                end
                DPW_T_ADDR, DPW_T_INSTR, DPW_T_DATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        if (state_q == DPW_T_ADDR) begin
                            if (rx_byte[7:1] == {ADDR_FIXED, asel_f}) begin
                                sda_oe_n_q <= 1'b0;
                                state_q <= DPW_T_ACK_ADDR;
                                master_ack_q <= rx_byte[0];
                            end else begin
                                state_q <= DPW_T_IDLE;
                            end
                        end else if (state_q == DPW_T_INSTR) begin
                            sda_oe_n_q <= 1'b0;
                            state_q <= DPW_T_ACK_INSTR;
                        end else begin
                            sda_oe_n_q <= 1'b0;
                            state_q <= DPW_T_ACK_DATA;
                        end
                    end
                end
                DPW_T_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (master_ack_q) begin
                            // First read bit goes out on this very fall
                            state_q <= DPW_T_READ;
                            sda_oe_n_q <= wiper_q[7];
                            shift_q <= {wiper_q[6:0], 1'b1};
                        end else begin
                            state_q <= DPW_T_INSTR;
                            sda_oe_n_q <= 1'b1;
                        end
                    end
                end
                DPW_T_ACK_INSTR, DPW_T_ACK_DATA: begin
                    if (scl_fall) begin
                        sda_oe_n_q <= 1'b1;
                        state_q <= DPW_T_DATA;
                    end
                end
                DPW_T_READ: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            sda_oe_n_q <= 1'b1;
                            state_q <= DPW_T_READ_ACK;
                        end else begin
                            sda_oe_n_q <= shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b1};
                        end
                    end
                end
                DPW_T_READ_ACK: begin
                    if (scl_rise) begin
                        master_ack_q <= sda_f;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (!master_ack_q) begin
                            // Repeated read of the same register
                            state_q <= DPW_T_READ;
                            sda_oe_n_q <= wiper_q[7];
                            shift_q <= {wiper_q[6:0], 1'b1};
                        end else begin
                            state_q <= DPW_T_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Stored wiper value and shutdown flag
    always_ff @(posedge mclk) begin
        if (srst) begin
            wiper_q <= WIPER_MIDSCALE;
            shutdown_q <= 1'b0;
        end else if (!start_det && !stop_det && scl_fall
                     && cnt_q == BITS_PER_BYTE) begin
            if (state_q == DPW_T_INSTR) begin
                // Bit 7 and bits 4..0 play no part
                if (rx_byte[INSTR_MID_RST_POS]) begin
                    wiper_q <= WIPER_MIDSCALE;
                end
                shutdown_q <= rx_byte[INSTR_SHDN_POS];
            end else if (state_q == DPW_T_DATA) begin
                wiper_q <= rx_byte;
            end
        end
    end

    // Applied tap: bottom terminal during shutdown, stored code otherwise
    always_ff @(posedge mclk) begin
        if (srst) begin
            tap_q <= WIPER_MIDSCALE;
            top_open_q <= 1'b0;
        end else begin
            tap_q <= shutdown_q ? WIPER_ZERO : wiper_q;
            top_open_q <= shutdown_q;
        end
    end

    // Open-drain data level is always low; the enable does the signalling
    always_ff @(posedge mclk) begin
        sda_o_q <= 1'b0;
    end

    assign bus.tgt_sda_oe_n = sda_oe_n_q;
    assign bus.tgt_sda_o = sda_o_q;
    assign wiper_register = wiper_q;
    assign tap_code = tap_q;
    assign top_open = top_open_q;
endmodule

// ---- logic/dpw_controller.sv ----
// Bus controller that runs wiper transfers from a register port
`timescale 1ns/1ns
module dpw_controller
    import dpw_pkg::*;
#(
    parameter int unsigned QUARTER_CYC = SCL_QUARTER_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    dpw_bus_if.ctl bus,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    logic [15:0] div_q;
    logic tick;
    logic [1:0] ph_q;
    dpw_ctl_state_t state_q;
    logic rd_mode_q;
    logic asel_q;
    logic [7:0] instr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic nack_q;
    logic done_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic last_byte;
    logic [7:0] cur_byte;
    logic scl_oe_n_q;
    logic sda_oe_n_q;
    logic [2:0] sda_s_q;
    logic sda_f_q;
    logic [7:0] rdata_out_q;
    logic go;

    assign go = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO_POS]
                && state_q == DPW_C_IDLE;
    assign tick = div_q == 16'(QUARTER_CYC - 1);
    assign last_byte = byte_q == (rd_mode_q ? 2'h1 : 2'h2);

    // Byte on the wire: address with direction, then instruction, then data; a read sends all ones after the address
    always_comb begin
        unique case (byte_q)
            2'h0: cur_byte = {ADDR_FIXED, asel_q, rd_mode_q};
            2'h1: cur_byte = rd_mode_q ? BYTE_ONES : instr_q;
            default: cur_byte = rd_mode_q ? BYTE_ONES : wdata_q;
        endcase
    end

    // Quarter-period divider for the serial clock
    always_ff @(posedge mclk) begin
        if (srst || state_q == DPW_C_IDLE || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // Returned data synchronised through three stages
    always_ff @(posedge mclk) begin
        if (srst) begin
            sda_s_q <= 3'h7;
            sda_f_q <= 1'b1;
        end else begin
            sda_s_q <= {sda_s_q[1:0], bus.sda};
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_f_q <= sda_s_q[2];
            end
        end
    end

    // Software-visible settings
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_mode_q <= 1'b0;
            asel_q <= 1'b0;
            instr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else if (reg_wr && state_q == DPW_C_IDLE) begin
            if (reg_addr == REG_CTRL) begin
                rd_mode_q <= reg_wdata[CTRL_READ_POS];
                asel_q <= reg_wdata[CTRL_ASEL_POS];
            end
            if (reg_addr == REG_INSTR) begin
                instr_q <= reg_wdata;
            end
            if (reg_addr == REG_WDATA) begin
                wdata_q <= reg_wdata;
            end
        end
    end

    // Transfer sequencer: four quarter phases per bit
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= DPW_C_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            rdata_q <= 8'h00;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else if (go) begin
            state_q <= DPW_C_START;
            ph_q <= 2'h0;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else if (state_q != DPW_C_IDLE && tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (state_q)
                DPW_C_START: begin
                    if (ph_q == 2'h0) begin
                        scl_oe_n_q <= 1'b1;
                        sda_oe_n_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        sda_oe_n_q <= 1'b0;
                    end else if (ph_q == 2'h3) begin
                        scl_oe_n_q <= 1'b0;
                        bit_q <= 4'h0;
                        byte_q <= 2'h0;
                        state_q <= DPW_C_BITS;
                    end
                end
                DPW_C_BITS: begin
                    if (ph_q == 2'h0) begin
                        // Ack slot and read bits leave the line released
                        if (bit_q == BITS_PER_BYTE) begin
                            sda_oe_n_q <= 1'b1;
                        end else begin
                            sda_oe_n_q <= cur_byte[3'(7 - bit_q)];
                        end
                    end else if (ph_q == 2'h1) begin
                        scl_oe_n_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        if (bit_q == BITS_PER_BYTE && !(rd_mode_q
                                && byte_q == 2'h1) && sda_f_q) begin
                            nack_q <= 1'b1;
                        end
                        if (rd_mode_q && byte_q == 2'h1
                                && bit_q != BITS_PER_BYTE) begin
                            rdata_q <= {rdata_q[6:0], sda_f_q};
                        end
                    end else begin
                        scl_oe_n_q <= 1'b0;
                        if (bit_q == BITS_PER_BYTE) begin
                            bit_q <= 4'h0;
                            byte_q <= byte_q + 2'h1;
                            if (last_byte || nack_q) begin
                                state_q <= DPW_C_STOP;
                            end
                        end else begin
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                DPW_C_STOP: begin
                    if (ph_q == 2'h0) begin
                        sda_oe_n_q <= 1'b0;
                    end else if (ph_q == 2'h1) begin
                        scl_oe_n_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        sda_oe_n_q <= 1'b1;
                    end else begin
                        state_q <= DPW_C_IDLE;
                        done_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= DPW_C_IDLE;
                end
            endcase
        end
    end

    // Read port: data one cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_out_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_out_q <= {5'h00, asel_q, rd_mode_q, 1'b0};
                REG_INSTR: rdata_out_q <= instr_q;
                REG_WDATA: rdata_out_q <= wdata_q;
                REG_RDATA: rdata_out_q <= rdata_q;
                REG_STATUS: rdata_out_q <= {5'h00, done_q, nack_q,
                                            state_q != DPW_C_IDLE};
                default: rdata_out_q <= 8'h00;
            endcase
        end else begin
            rdata_out_q <= 8'h00;
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.ctl_sda_o = 1'b0;
    assign bus.scl_oe_n = scl_oe_n_q;
    assign bus.ctl_sda_oe_n = sda_oe_n_q;
    assign reg_rdata = rdata_out_q;
endmodule

// ---- tb/dpw_monitor.sv ----
// Wire-level checks of the two-wire link and the target's wiper outputs
`timescale 1ns/1ns
module dpw_monitor
    import dpw_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    input wire logic tgt_sda_oe_n,
    input wire logic addr_select_pin,
    input wire logic [7:0] wiper_register,
    input wire logic [7:0] tap_code,
    input wire logic top_open
);
    logic scl_q, sda_q, rd_q, mute_q;
    logic [3:0] slot_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    logic rise, fall, start;

    // Edges of the resolved lines
    assign rise = scl && !scl_q;
    assign fall = !scl && scl_q;
    assign start = scl && scl_q && sda_q && !sda;

    // Previous line levels
    always_ff @(posedge mclk) begin
        if (srst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // Pulse slot within the byte and byte count since START
    always_ff @(posedge mclk) begin
        if (srst || start) begin
            slot_q <= 4'h0;
            byte_q <= 3'h0;
        end else if (rise && slot_q == 4'h8) begin
            slot_q <= 4'h0;
            byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
        end else if (rise) begin
            slot_q <= slot_q + 4'h1;
        end
    end

    // Bits sampled on each clock rise
    always_ff @(posedge mclk) begin
        if (srst) begin
            sh_q <= 8'h00;
        end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
        end
    end

    // Direction of the transfer and missing address acknowledge
    always_ff @(posedge mclk) begin
        if (srst || start) begin
            rd_q <= 1'b0;
            mute_q <= 1'b0;
        end else if (rise && byte_q == 3'h0 && slot_q == 4'h7) begin
            rd_q <= sda;
        end else if (rise && byte_q == 3'h0 && slot_q == 4'h8) begin
            mute_q <= sda;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_addr_ack_match: assert property (
        rise && slot_q == 4'h8 && byte_q == 3'h0
        |-> sda == (sh_q[7:1] != {ADDR_FIXED, addr_select_pin}))
        else $error("address acknowledge does not follow the address");
    a_mismatch_silent: assert property (
        mute_q |-> tgt_sda_oe_n)
        else $error("target drives data after a foreign address");
    a_ack_release: assert property (
        fall && slot_q == 4'h0 && byte_q != 3'h0 && !rd_q
        |-> ##[1:8] tgt_sda_oe_n)
        else $error("target holds data line after acknowledge");
    a_drive_slot: assert property (
        !tgt_sda_oe_n && scl && scl_q |-> (slot_q == 4'h0 ?
        (byte_q == 3'h1 || (byte_q > 3'h1 && !rd_q)) :
        (rd_q && byte_q != 3'h0)))
        else $error("target drives data line outside its slots");
    a_read_bits: assert property (
        rise && rd_q && !mute_q && byte_q == 3'h1 && slot_q != 4'h8
        |-> sda == wiper_register[3'h7 - slot_q[2:0]])
        else $error("read bit differs from stored wiper");
    a_instr_mid: assert property (
        fall && slot_q == 4'h8 && byte_q == 3'h1 && !rd_q && !mute_q
        && sh_q[INSTR_MID_RST_POS]
        |-> ##[1:10] wiper_register == WIPER_MIDSCALE)
        else $error("midscale reset not applied");
    a_instr_shdn: assert property (
        fall && slot_q == 4'h8 && byte_q == 3'h1 && !rd_q && !mute_q
        |-> ##[1:10] top_open == sh_q[INSTR_SHDN_POS])
        else $error("shutdown state does not follow instruction");
    a_data_store: assert property (
        fall && slot_q == 4'h8 && byte_q > 3'h1 && !rd_q && !mute_q
        |-> ##[1:10] wiper_register == sh_q)
        else $error("data byte not stored in wiper");
    a_tap_applied: assert property (
        $stable(wiper_register) && $stable(top_open)
        |-> tap_code == (top_open ? WIPER_ZERO : wiper_register))
        else $error("applied tap differs from stored wiper");
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench: controller and target joined over the link
`timescale 1ns/1ns
module testbench;
    import dpw_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, wiper_register, tap_code, d;
    logic addr_select_pin = 1'b0;
    logic top_open;
    logic mid_seen = 1'b0;
    logic [7:0] edge_vals [2] = '{8'h00, 8'hFF};
    int error_cnt = 0;
    int num_checks = 0;

    dpw_bus_if dpw_bus_if_i ();
    dpw_controller #(.QUARTER_CYC(8)) dpw_controller_i (
        .mclk(mclk), .srst(srst), .bus(dpw_bus_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    dpw_target dpw_target_i (
        .mclk(mclk), .srst(srst), .bus(dpw_bus_if_i),
        .addr_select_pin(addr_select_pin), .wiper_register(wiper_register),
        .tap_code(tap_code), .top_open(top_open));
    dpw_monitor dpw_monitor_i (
        .mclk(mclk), .srst(srst), .scl(dpw_bus_if_i.scl),
        .sda(dpw_bus_if_i.sda), .tgt_sda_oe_n(dpw_bus_if_i.tgt_sda_oe_n),
        .addr_select_pin(addr_select_pin), .wiper_register(wiper_register),
        .tap_code(tap_code), .top_open(top_open));

    // Clock and midscale watcher
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    always @(posedge mclk) begin
        if (wiper_register === WIPER_MIDSCALE) begin
            mid_seen <= 1'b1;
        end
    end

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // One transfer, polled to completion, status compared
    task automatic run(input logic [7:0] instr, input logic [7:0] data,
                       input logic rd, input logic asel, input logic nack);
        logic [7:0] st;
        int n;
        reg_write(REG_INSTR, instr);
        reg_write(REG_WDATA, data);
        reg_write(REG_CTRL, {5'h00, asel, rd, 1'b1});
        n = 0;
        do begin
            reg_read(REG_STATUS, st);
            n++;
        end while (st[STAT_BUSY_POS] !== 1'b0 && n < 2000);
        check("status", {5'h00, 1'b1, nack, 1'b0}, st & 8'h07);
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        error_cnt++;
        $display("MISMATCH watchdog expected done seen hang");
        results();
    end

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        check("wiper", WIPER_MIDSCALE, wiper_register);
        check("tap", 8'h80, tap_code);
        check("top", 8'h00, {7'h00, top_open});
        reg_read(5'h14, d);
        check("unmapped", 8'h00, d);
        // Write with every ignored instruction bit set
        run(8'h9F, 8'h3C, 1'b0, 1'b0, 1'b0);
        check("wiper", 8'h3C, wiper_register);
        run(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
        reg_read(REG_RDATA, d);
        check("rdata", 8'h3C, d);
        // Foreign address: no acknowledge, wiper kept
        run(8'h00, 8'h55, 1'b0, 1'b1, 1'b1);
        check("wiper", 8'h3C, wiper_register);
        addr_select_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        run(8'h00, 8'hC3, 1'b0, 1'b1, 1'b0);
        check("wiper", 8'hC3, wiper_register);
        // Midscale reset passes through 0x80 before the data byte
        mid_seen <= 1'b0;
        run(8'h40, 8'h77, 1'b0, 1'b1, 1'b0);
        check("midscale", 8'h01, {7'h00, mid_seen});
        check("wiper", 8'h77, wiper_register);
        // Shutdown while writing a new code
        run(8'h20, 8'h11, 1'b0, 1'b1, 1'b0);
        check("top", 8'h01, {7'h00, top_open});
        check("tap", WIPER_ZERO, tap_code);
        check("wiper", 8'h11, wiper_register);
        run(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
        reg_read(REG_RDATA, d);
        check("rdata", 8'h11, d);
        // Leave shutdown: stored code applied again
        run(8'h9F, 8'hE7, 1'b0, 1'b1, 1'b0);
        check("top", 8'h00, {7'h00, top_open});
        check("tap", 8'hE7, tap_code);
        // End codes of the tap range
        foreach (edge_vals[i]) begin
            run(8'h1F, edge_vals[i], 1'b0, 1'b1, 1'b0);
            check("tap", edge_vals[i], tap_code);
            run(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
            reg_read(REG_RDATA, d);
            check("rdata", edge_vals[i], d);
        end
        results();
    end
endmodule
